// File: hw/dmabm_arbiter.sv
/*
 * dmabm_arbiter: bus request, take-over and release handshake of a dma
 * controller, plus cycle-steal request windows and exception holdoff.
 * assumes the arbiter and host share clk_in; all inputs synchronous.
 * half-clock steps are realised as one full clock of this block's clock.
 */
`default_nettype none
module dmabm_arbiter #(
    parameter int CHANNELS = 4
) (
    input  wire logic                    clk_in,
    input  wire logic                    rst_n_in,
    input  wire logic [CHANNELS-1:0]     channel_request_in,
    input  wire logic [CHANNELS-1:0]     ignore_window_in,
    input  wire dmabm_pkg::dmabm_bus_in_t bus_in,
    input  wire logic [2:0]              exception_code_in,
    input  wire logic                    last_cycle_done_in,
    output logic                         bus_request_out,
    output logic                         own_out,
    output logic                         grant_acknowledge_out,
    output logic                         grant_acknowledge_oe_out,
    output logic                         cycle_start_out,
    output logic [CHANNELS-1:0]          channel_serviced_out
);
    // ****************************************
    // cycle-steal request windows
    // ****************************************
    logic [CHANNELS-1:0] req_prev;
    logic [CHANNELS-1:0] pending;
    logic [CHANNELS-1:0] in_window;
    logic [1:0]          hold_cnt [CHANNELS];
    logic [CHANNELS-1:0] grant_sel;

    function automatic logic [CHANNELS-1:0] first_one(input logic [CHANNELS-1:0] v);
        logic [CHANNELS-1:0] r;
        r = '0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            req_prev  <= '0;
            in_window <= '0;
            pending   <= '0;
            for (int i = 0; i < CHANNELS; i++) begin
                hold_cnt[i] <= 2'h0;
            end
        end else begin
            req_prev <= channel_request_in;
            for (int i = 0; i < CHANNELS; i++) begin
                // clear first, so a new set in the same cycle wins
                if (channel_serviced_out[i]) begin
                    pending[i] <= 1'b0;
                end
                // edge inside an ignore window is only tracked
                if (channel_request_in[i] && !req_prev[i]) begin
                    in_window[i] <= ignore_window_in[i];
                    hold_cnt[i]  <= 2'h0;
                    if (!ignore_window_in[i]) begin
                        pending[i] <= 1'b1;
                    end
                end else if (in_window[i] && channel_request_in[i]
                             && !ignore_window_in[i]) begin
                    // held into following window: counts as new
                    if (hold_cnt[i] == 2'(dmabm_pkg::CS_MIN_PULSE_CLKS - 1)) begin
                        pending[i]   <= 1'b1;
                        in_window[i] <= 1'b0;
                    end else begin
                        hold_cnt[i] <= hold_cnt[i] + 2'h1;
                    end
                end else if (in_window[i] && !channel_request_in[i]) begin
                    in_window[i] <= 1'b0; // dropped inside window
                end
            end
        end
    end

    // ****************************************
    // exception holdoff
    // ****************************************
    logic       halted;
    logic       retry_wait;
    logic [1:0] rearb_cnt;
    logic       holdoff;

    assign holdoff = halted || (rearb_cnt != 2'h0);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            halted     <= 1'b0;
            retry_wait <= 1'b0;
            rearb_cnt  <= 2'h0;
        end else begin
            halted     <= (exception_code_in == dmabm_pkg::EXC_HALT)
                          || (exception_code_in == dmabm_pkg::EXC_RELINQ);
            retry_wait <= exception_code_in == dmabm_pkg::EXC_RETRY;
            if (halted && exception_code_in == dmabm_pkg::EXC_NORMAL) begin
                rearb_cnt <= 2'(dmabm_pkg::HALT_REARB_CLKS);
            end else if (rearb_cnt != 2'h0) begin
                rearb_cnt <= rearb_cnt - 2'h1;
            end
        end
    end

    // ****************************************
    // mastership state machine
    // ****************************************
    dmabm_pkg::dmabm_state_t state;
    logic [dmabm_pkg::CNT_W-1:0] lead_cnt;
    logic host_access;
    logic any_pending;
    logic [CHANNELS-1:0] waiting;

    // a channel in its serviced cycle is no longer a candidate
    assign waiting     = pending & ~channel_serviced_out;
    assign host_access = bus_in.chip_select || bus_in.interrupt_ack;
    assign any_pending = |waiting;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state                    <= dmabm_pkg::ST_IDLE;
            bus_request_out          <= 1'b0;
            own_out                  <= 1'b0;
            grant_acknowledge_out    <= 1'b0;
            grant_acknowledge_oe_out <= 1'b0;
            cycle_start_out          <= 1'b0;
            channel_serviced_out     <= '0;
            grant_sel                <= '0;
            lead_cnt                 <= '0;
        end else begin
            cycle_start_out      <= 1'b0;
            channel_serviced_out <= '0;
            if (lead_cnt != '0) begin
                lead_cnt <= lead_cnt - 1'b1;
            end
            unique case (state)
                dmabm_pkg::ST_IDLE: begin
                    if (any_pending && !holdoff) begin
                        state           <= dmabm_pkg::ST_REQ;
                        bus_request_out <= !host_access;
                        lead_cnt        <= dmabm_pkg::CNT_W'(dmabm_pkg::REQ_TO_CYCLE_CLKS - 1);
                    end
                end
                dmabm_pkg::ST_REQ: begin
                    bus_request_out <= !host_access;
                    if (!host_access && bus_in.grant) begin
                        state <= dmabm_pkg::ST_WAITREL;
                    end
                end
                dmabm_pkg::ST_WAITREL: begin
                    bus_request_out <= !host_access;
                    if (!bus_in.grant) begin
                        state <= dmabm_pkg::ST_REQ;
                    end else if (!bus_in.addr_strobe && !bus_in.grant_ack) begin
                        state   <= dmabm_pkg::ST_OWN;
                        own_out <= 1'b1;
                        grant_acknowledge_oe_out <= 1'b1;
                    end
                end
                dmabm_pkg::ST_OWN: begin
                    grant_acknowledge_out <= 1'b1;
                    state <= dmabm_pkg::ST_ACK;
                end
                dmabm_pkg::ST_ACK: begin
                    bus_request_out <= 1'b0;
                    // one channel at a time, serialised
                    if (grant_sel == '0 && lead_cnt == '0 && any_pending && !retry_wait) begin
                        grant_sel       <= first_one(waiting);
                        cycle_start_out <= 1'b1;
                    end else if (grant_sel != '0 && last_cycle_done_in && !retry_wait) begin
                        channel_serviced_out <= grant_sel;
                        grant_sel            <= '0;
                        if ((pending & ~grant_sel) == '0 || halted) begin
                            grant_acknowledge_out <= 1'b0;
                            state <= dmabm_pkg::ST_RELEASE;
                        end
                    end
                end
                dmabm_pkg::ST_RELEASE: begin
                    own_out                  <= 1'b0;
                    grant_acknowledge_oe_out <= 1'b0;
                    state                    <= dmabm_pkg::ST_IDLE;
                end
                default: begin
                    state <= dmabm_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_take;
        !own_out ##1 own_out && !grant_acknowledge_out;
    endsequence
    property p_own_first;
        s_take |=> grant_acknowledge_out;
    endproperty
    a_own_first: assert property (p_own_first) else $error("ack not after own");

    property p_take_cond;
        $rose(own_out) |-> $past(!bus_in.addr_strobe && !bus_in.grant_ack && bus_in.grant);
    endproperty
    a_take_cond: assert property (p_take_cond) else $error("bus taken while busy");

    property p_req_drop;
        $rose(grant_acknowledge_out) |=> !bus_request_out;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("request not dropped");

    property p_release;
        $fell(grant_acknowledge_out) |-> own_out ##1 !own_out;
    endproperty
    a_release: assert property (p_release) else $error("own not released after ack");

    property p_host_withdraw;
        (state == dmabm_pkg::ST_REQ && host_access) |=> !bus_request_out;
    endproperty
    a_host_withdraw: assert property (p_host_withdraw) else $error("request kept");

    property p_lead;
        state == dmabm_pkg::ST_REQ && $past(state) == dmabm_pkg::ST_IDLE
            |-> !cycle_start_out [*8] ##1 !cycle_start_out [*3];
    endproperty
    a_lead: assert property (p_lead) else $error("cycle started too early");

    property p_halt_wait;
        $fell(halted) |-> !$rose(bus_request_out) [*3];
    endproperty
    a_halt_wait: assert property (p_halt_wait) else $error("rearbitrated too soon");

    property p_retry_hold;
        (retry_wait && grant_acknowledge_out) |=> grant_acknowledge_out;
    endproperty
    a_retry_hold: assert property (p_retry_hold) else $error("ack lost in retry");

    property p_one_channel;
        $onehot0(grant_sel);
    endproperty
    a_one_channel: assert property (p_one_channel) else $error("channels overlap");
endmodule
`default_nettype wire

// File: hw/dmabm_pkg.sv
/*
 * dmabm_pkg: constants and carrier structs for the dma bus mastership block.
 * assumes a single 100 MHz clock shared with the external arbiter.
 */
`default_nettype none
package dmabm_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS        = 10;
    localparam int REQ_TO_CYCLE_CLKS    = 12;
    localparam int HALT_REARB_CLKS      = 3;
    localparam int CS_MIN_PULSE_CLKS    = 2;
    localparam int CNT_W                = 5;

    // ****************************************
    // exception codes
    // ****************************************
    localparam logic [2:0] EXC_NORMAL   = 3'h0;
    localparam logic [2:0] EXC_HALT     = 3'h1;
    localparam logic [2:0] EXC_RETRY    = 3'h3;
    localparam logic [2:0] EXC_RELINQ   = 3'h4;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic grant;
        logic addr_strobe;
        logic grant_ack;
        logic chip_select;
        logic interrupt_ack;
    } dmabm_bus_in_t;

    typedef struct packed {
        logic bus_request;
        logic own;
        logic grant_ack_drive;
    } dmabm_bus_out_t;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'b00_0001,
        ST_REQ     = 6'b00_0010,
        ST_WAITREL = 6'b00_0100,
        ST_OWN     = 6'b00_1000,
        ST_ACK     = 6'b01_0000,
        ST_RELEASE = 6'b10_0000
    } dmabm_state_t;
endpackage
`default_nettype wire

// File: sim/dma_bus_mastership_handshake_tb.sv
/* dma_bus_mastership_handshake_tb: random and corner tests of dmabm_arbiter.
 * assumes dmabm_host_model as bus partner; inputs change at falling edge. */
`default_nettype none
module dma_bus_mastership_handshake_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, rst_n_in, cs, int_ack, done, bus_req, own, ack, oe, start, gnt;
    logic strobe_l, ack_line;
    logic [3:0] req, win, serv;
    logic [2:0] exc;
    logic [1:0] slow;
    logic p_own, p_ack, pp_ack, p_strobe, armed, seen;
    int errors, compares, cyc, t_req;
    dmabm_pkg::dmabm_bus_in_t bi;
    assign ack_line = oe ? ack : 1'b0;
    assign bi = '{grant:gnt, addr_strobe:strobe_l, grant_ack:ack_line,
                  chip_select:cs, interrupt_ack:int_ack};
    dmabm_arbiter #(.CHANNELS(4)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .channel_request_in(req), .ignore_window_in(win), .bus_in(bi),
        .exception_code_in(exc), .last_cycle_done_in(done), .bus_request_out(bus_req),
        .own_out(own), .grant_acknowledge_out(ack), .grant_acknowledge_oe_out(oe),
        .cycle_start_out(start), .channel_serviced_out(serv));
    dmabm_host_model host_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_request_in(bus_req),
        .grant_ack_in(ack_line), .slow_in(slow), .grant_out(gnt), .addr_strobe_out(strobe_l));
    // ****************************************
    // checking helpers
    // ****************************************
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic test_done;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    function automatic logic pick(input int s);
        return (s == 0) ? bus_req : (s == 1) ? start : !own;
    endfunction
    task automatic wait_for(input int s, input int lim);
        int n;
        n = 0;
        while (pick(s) !== 1'b1 && n < lim) begin
            @(negedge clk_in);
            n++;
        end
        check("wait", 1, pick(s));
    endtask
    task automatic raise(input logic [3:0] m);
        req   = req | m;
        t_req = cyc;
        armed = 1'b1;
    endtask
    task automatic serve(input logic [3:0] m);
        for (int i = 0; i < 4; i++) begin
            if (m[i]) begin
                wait_for(1, 80);
                repeat ($urandom_range(1, 4)) @(negedge clk_in);
                req[i] = 1'b0;
                done   = 1'b1;
                @(negedge clk_in);
                done   = 1'b0;
                check("serviced", 32'h1 << i, serv);
            end
        end
        wait_for(2, 10);
        repeat (4) @(negedge clk_in);
    endtask
    // ****************************************
    // handshake monitor, sampled at falling edge
    // ****************************************
    always @(negedge clk_in) begin
        if (rst_n_in) begin
            cyc++;
            if (own && !p_own) check("take_strobe", 0, p_strobe);
            if (own && !p_own) check("ack_after_own", 0, ack);
            if (ack && !p_ack) check("own_before_ack", 1, p_own);
            if (ack && !p_ack) check("req_held", 1, bus_req);
            if (p_ack && !pp_ack) check("req_drop", 0, bus_req);
            if (p_ack && !ack) check("own_after_rel", 1, own);
            if (p_own && !own) check("ack_before_own", 0, p_ack);
            check("oe_own", own, oe);
            if (start && armed) check("req_to_cycle", 1, (cyc - t_req) >= 12);
            if (start) armed = 1'b0;
            check("serv_onehot", 1, $countones(serv) <= 1);
            pp_ack   = p_ack;
            p_ack    = ack;
            p_own    = own;
            p_strobe = strobe_l;
        end
    end
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        test_done();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst_n_in, cs, int_ack, done, req, win, exc, slow} = '0;
        {p_own, p_ack, pp_ack, p_strobe, armed, seen} = '0;
        errors = 0;
        compares = 0;
        cyc = 0;
        void'($urandom(32'hea23237c));
        repeat (6) @(negedge clk_in);
        rst_n_in = 1'b1;
        check("reset_outs", 0, {bus_req, own, ack, oe});
        repeat (3) @(negedge clk_in);
        check("idle_outs", 0, {bus_req, own, ack});
        for (int k = 0; k < 12; k++) begin
            slow = 2'($urandom_range(0, 3));
            raise(4'($urandom_range(1, 15)));
            repeat (2) @(negedge clk_in);
            check("req_rise", 1, bus_req);
            serve(req);
        end
        slow = 2'h3;
        for (int k = 0; k < 2; k++) begin
            raise(4'h2);
            repeat (2) @(negedge clk_in);
            {cs, int_ack} = k ? 2'b01 : 2'b10;
            @(negedge clk_in);
            check("req_withdrawn", 0, bus_req);
            repeat (3) @(negedge clk_in);
            {cs, int_ack} = 2'b00;
            wait_for(0, 4);
            serve(4'h2);
        end
        for (int k = 0; k < 2; k++) begin
            exc = k ? dmabm_pkg::EXC_RELINQ : dmabm_pkg::EXC_HALT;
            raise(4'h1);
            repeat (6) @(negedge clk_in);
            check("req_halted", 0, bus_req);
            exc = dmabm_pkg::EXC_NORMAL;
            repeat (2) @(negedge clk_in);
            check("req_holdoff", 0, bus_req);
            wait_for(0, 6);
            serve(4'h1);
        end
        slow = 2'h0;
        raise(4'h4);
        wait_for(0, 4);
        wait_for(1, 80);
        exc = dmabm_pkg::EXC_RETRY;
        repeat (2) @(negedge clk_in);
        done = 1'b1;
        @(negedge clk_in);
        done = 1'b0;
        check("retry_serv", 0, serv);
        repeat (2) @(negedge clk_in);
        check("retry_ack", 1, ack);
        exc = dmabm_pkg::EXC_NORMAL;
        req[2] = 1'b0;
        @(negedge clk_in);
        done = 1'b1;
        @(negedge clk_in);
        done = 1'b0;
        check("retry_done", 32'h4, serv);
        wait_for(2, 10);
        repeat (4) @(negedge clk_in);
        win = 4'h8;
        req[3] = 1'b1;
        repeat (2) @(negedge clk_in);
        req[3] = 1'b0;
        @(negedge clk_in);
        win = 4'h0;
        repeat (8) begin
            @(negedge clk_in);
            seen = seen | bus_req;
        end
        check("short_steal", 0, seen);
        win = 4'h8;
        raise(4'h8);
        @(negedge clk_in);
        win = 4'h0;
        wait_for(0, 8);
        serve(4'h8);
        test_done();
    end
endmodule
`default_nettype wire

// File: sim/dmabm_host_model.sv
/* dmabm_host_model: host processor and bus arbiter beside the dma block.
 * assumes the shared clk_in; grant_ack_in is the resolved wire level. */
`default_nettype none
module dmabm_host_model (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       bus_request_in,
    input  wire logic       grant_ack_in,
    input  wire logic [1:0] slow_in,
    output logic            grant_out,
    output logic            addr_strobe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_cnt;
    logic [2:0] phase;
    logic [1:0] hold;
    // ****************************************
    // arbiter grant, prompt or slow
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            grant_out <= 1'b0;
            wait_cnt  <= 2'h0;
        end else if (!bus_request_in) begin
            grant_out <= 1'b0;
            wait_cnt  <= 2'h0;
        end else if (!grant_out) begin
            grant_out <= (wait_cnt == slow_in);
            wait_cnt  <= wait_cnt + 2'h1;
        end
    end
    // ****************************************
    // host bus cycles, five clocks each
    // ****************************************
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase           <= 3'h0;
            addr_strobe_out <= 1'b0;
            hold            <= 2'h0;
        end else if (grant_ack_in) begin
            phase           <= 3'h0;
            addr_strobe_out <= 1'b0;
            hold            <= 2'h2;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end else if (phase == 3'h0 && grant_out) begin
            addr_strobe_out <= 1'b0;
        end else begin
            phase           <= (phase == 3'h4) ? 3'h0 : phase + 3'h1;
            addr_strobe_out <= (phase < 3'h3);
        end
    end
endmodule
`default_nettype wire
